// ### common/ais_defines.svh
// Constants for the input selection and burnout control block.
// Assumes inclusion by bare name from any design file that needs them.
`ifndef AIS_DEFINES_SVH
`define AIS_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define AIS_OFS_CFG_FIRST 4'h0
`define AIS_OFS_SELECT 4'h4
`define AIS_OFS_CONTROL 4'h8
`define AIS_OFS_STATUS 4'hC

// ****************************************
// Field positions
// ****************************************
`define AIS_CS_LSB 0
`define AIS_CS_MSB 1
`define AIS_POS_LSB 4
`define AIS_POS_MSB 7
`define AIS_NEG_LSB 0
`define AIS_NEG_MSB 3
`define AIS_CTL_SEQ 0
`define AIS_CTL_SHDN 1
`define AIS_CTL_CRST 2

// ****************************************
// Reset values and fixed codes
// ****************************************
`define AIS_CFG_FIRST_RST 2'h0
`define AIS_SELECT_RST 8'h01
`define AIS_TEMP_FULL 8'hDE

`endif

// ### common/ais_pkg.sv
// Types shared by the input selection and burnout control block.
// Assumes nothing of its surroundings.
`default_nettype none

package ais_pkg;

   // Sixteen sources offered to each single-ended selector
   typedef enum logic [3:0] {
      AIS_SRC_CHAN0 = 4'h0,
      AIS_SRC_CHAN7 = 4'h7,
      AIS_SRC_GND = 4'h8,
      AIS_SRC_SUPPLY = 4'h9,
      AIS_SRC_RSVD = 4'hA,
      AIS_SRC_REFP = 4'hB,
      AIS_SRC_REFN = 4'hC,
      AIS_SRC_TEMP_P = 4'hD,
      AIS_SRC_TEMP_M = 4'hE,
      AIS_SRC_CM = 4'hF
   } ais_source_type;

endpackage : ais_pkg

`default_nettype wire

// ### common/ais_sel_if.sv
// Carries the effective selection code to the decoder and its switch enables back.
// Assumes both ends sit in the same clock domain; the path is purely combinational.
`default_nettype none

interface ais_sel_if;
   logic [7:0] code;
   logic [15:0] pos_en;
   logic [15:0] neg_en;
   logic temp_sel;

   modport src (output code, input pos_en, input neg_en, input temp_sel);
   modport dec (input code, output pos_en, output neg_en, output temp_sel);
endinterface : ais_sel_if

`default_nettype wire

// ### core/ais_decoder.sv
// Decodes an 8-bit selection into two independent one-hot switch vectors.
// Assumes the caller registers the outputs; no state is held here.
`default_nettype none
`include "ais_defines.svh"

module ais_decoder (
   ais_sel_if.dec sel
);

   function automatic logic [15:0] ais_onehot(input logic [3:0] code);
      ais_onehot = 16'h0001 << code;
   endfunction : ais_onehot

   function automatic logic ais_is_temp(input logic [3:0] code);
      ais_is_temp = (code == ais_pkg::AIS_SRC_TEMP_P) || (code == ais_pkg::AIS_SRC_TEMP_M);
   endfunction : ais_is_temp

   // Same table on both sides, no cross terms
   assign sel.pos_en = ais_onehot(sel.code[`AIS_POS_MSB:`AIS_POS_LSB]);
   assign sel.neg_en = ais_onehot(sel.code[`AIS_NEG_MSB:`AIS_NEG_LSB]);
   // Either diode on either side counts as a temperature selection
   assign sel.temp_sel = ais_is_temp(sel.code[`AIS_POS_MSB:`AIS_POS_LSB])
      || ais_is_temp(sel.code[`AIS_NEG_MSB:`AIS_NEG_LSB]);

endmodule : ais_decoder

`default_nettype wire

// ### core/ais_top.sv
// Front-end selection and burnout control with an APB register slave.
// Assumes an APB master on pclk and a sequencer on the same clock.
`default_nettype none
`include "ais_defines.svh"

// Functional notes
// - The upper nibble of the selection picks the source of the positive converter input.
// - The lower nibble of the selection picks the source of the negative converter input.
// - In direct mode codes 0 to 7 connect external analog channels zero to seven.
// - Codes 8 to 15 select ground, supply, reserved, references, diodes and bias.
// - Both selectors decode independently from the same sixteen-entry table.
// - In sequencer mode both selectors follow the sequencer code instead of the field.
// - The burnout current is sourced on the positive input and sunk on the negative.
// - The burnout enable ignores idle, converter reset and shutdown.
// - The two-bit current select is writable any time and reaches the burnout outputs one clock after the register updates.
// - A diode selection disables the burnout source but keeps the stored select bits.
// - The full value 0xDE puts the positive diode on plus and negative diode on minus.
module ais_top #(
   parameter int ADDR_WIDTH = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Sequencer position
   input wire logic [7:0] seq_code,
   // Switch enables
   output logic [15:0] pos_switch_en,
   output logic [15:0] neg_switch_en,
   // Burnout current level, source side and sink side
   output logic [1:0] burnout_source_en,
   output logic [1:0] burnout_sink_en
);

   // ****************************************
   // Elaboration check
   // ****************************************
   if (ADDR_WIDTH < 4) begin : g_bad_width
      $error("ADDR_WIDTH below 4 cannot hold the register map");
   end

   // ****************************************
   // Registers and decode
   // ****************************************
   logic [1:0] cs_sel;
   logic [7:0] select;
   logic seq_mode;
   logic shutdown;
   logic [7:0] eff_code;
   logic wr_en;
   logic setup;
   logic mapped;
   logic [3:0] word_addr;
   logic [31:0] next_prdata;

   ais_sel_if sel_bus ();

   ais_decoder u_decoder (
      .sel(sel_bus.dec)
   );

   assign word_addr = {paddr[3:2], 2'b00};
   assign setup = psel && !penable;
   assign wr_en = psel && penable && pready && pwrite;
   // Shift keeps the check legal at the minimum width, where no upper bits exist
   assign mapped = ((paddr >> 4) == '0) && (paddr[1:0] == 2'b00);

   // Sequencer overrides the user field
   assign eff_code = seq_mode ? seq_code : select;
   assign sel_bus.code = eff_code;

   // ****************************************
   // APB answer
   // ****************************************
   always_comb begin
      next_prdata = 32'h0000_0000;
      case (word_addr)
         `AIS_OFS_CFG_FIRST: next_prdata = {30'h0, cs_sel};
         `AIS_OFS_SELECT: next_prdata = {24'h0, select};
         `AIS_OFS_CONTROL: next_prdata = {30'h0, shutdown, seq_mode};
         `AIS_OFS_STATUS: next_prdata = {21'h0, sel_bus.temp_sel, burnout_source_en, eff_code};
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   // One wait-free access cycle; data prepared during setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= !mapped;
            prdata <= (mapped && !pwrite) ? next_prdata : 32'h0000_0000;
         end
      end
   end

   // ****************************************
   // Software state
   // ****************************************
   // Not touched by the converter reset bit, so burnout survives it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cs_sel <= `AIS_CFG_FIRST_RST;
      end else if (wr_en && mapped && word_addr == `AIS_OFS_CFG_FIRST) begin
         cs_sel <= pwdata[`AIS_CS_MSB:`AIS_CS_LSB];
      end
   end

   // Converter reset restores selection, sequencer mode and shutdown only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         select <= `AIS_SELECT_RST;
         seq_mode <= 1'b0;
         shutdown <= 1'b0;
      end else if (wr_en && mapped && word_addr == `AIS_OFS_CONTROL) begin
         if (pwdata[`AIS_CTL_CRST]) begin
            select <= `AIS_SELECT_RST;
            seq_mode <= 1'b0;
            shutdown <= 1'b0;
         end else begin
            seq_mode <= pwdata[`AIS_CTL_SEQ];
            shutdown <= pwdata[`AIS_CTL_SHDN];
         end
      end else if (wr_en && mapped && word_addr == `AIS_OFS_SELECT) begin
         select <= pwdata[7:0];
      end
   end

   // ****************************************
   // Analog controls
   // ****************************************
   // Shutdown opens every switch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos_switch_en <= 16'h0000;
         neg_switch_en <= 16'h0000;
      end else begin
         pos_switch_en <= shutdown ? 16'h0000 : sel_bus.pos_en;
         neg_switch_en <= shutdown ? 16'h0000 : sel_bus.neg_en;
      end
   end

   // Independent of shutdown and converter reset; diodes have their own bias
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         burnout_source_en <= 2'h0;
         burnout_sink_en <= 2'h0;
      end else begin
         burnout_source_en <= sel_bus.temp_sel ? 2'h0 : cs_sel;
         burnout_sink_en <= sel_bus.temp_sel ? 2'h0 : cs_sel;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   pos_direct_a : assert property (!seq_mode && !shutdown |=>
      pos_switch_en == (16'h0001 << $past(select[7:4])))
      else $error("positive enables do not follow upper nibble");
   neg_direct_a : assert property (!seq_mode && !shutdown |=>
      neg_switch_en == (16'h0001 << $past(select[3:0])))
      else $error("negative enables do not follow lower nibble");
   ext_channel_a : assert property (!shutdown && eff_code[7] == 1'b0 |=>
      pos_switch_en[15:8] == 8'h00 && $onehot(pos_switch_en[7:0]))
      else $error("external code did not pick one channel");
   int_source_a : assert property (!shutdown && eff_code[3] |=>
      neg_switch_en[7:0] == 8'h00 && $onehot(neg_switch_en[15:8]))
      else $error("internal code reached an external channel");
   side_indep_a : assert property ($stable(eff_code[7:4])
      ##1 ($stable(eff_code[7:4]) && $stable(shutdown)) |=> $stable(pos_switch_en))
      else $error("positive side moved with the negative code");
   seq_follow_a : assert property (seq_mode && !shutdown |=>
      pos_switch_en == (16'h0001 << $past(seq_code[7:4]))
      && neg_switch_en == (16'h0001 << $past(seq_code[3:0])))
      else $error("sequencer position not applied");
   burn_pair_a : assert property (burnout_source_en == burnout_sink_en)
      else $error("source and sink currents differ");
   burn_hold_a : assert property (!sel_bus.temp_sel && shutdown |=>
      burnout_source_en == $past(cs_sel))
      else $error("burnout dropped during shutdown");
   cs_write_a : assert property (wr_en && mapped && word_addr == `AIS_OFS_CFG_FIRST
      ##1 !sel_bus.temp_sel |=> burnout_source_en == $past(pwdata[1:0], 2))
      else $error("current select write not applied");
   temp_off_a : assert property (sel_bus.temp_sel |=>
      burnout_source_en == 2'h0 && (cs_sel == $past(cs_sel) || $past(wr_en)))
      else $error("diode selection left burnout on");
   neg_indep_a : assert property ($stable(eff_code[3:0])
      ##1 ($stable(eff_code[3:0]) && $stable(shutdown)) |=> $stable(neg_switch_en))
      else $error("negative side moved with the positive code");
   crst_keep_a : assert property (wr_en && mapped && word_addr == `AIS_OFS_CONTROL
      |=> cs_sel == $past(cs_sel))
      else $error("control write touched the current select");
   temp_code_a : assert property (eff_code == `AIS_TEMP_FULL && !shutdown |=>
      pos_switch_en == 16'h2000 && neg_switch_en == 16'h4000 && burnout_sink_en == 2'h0)
      else $error("full diode code not applied");

   temp_full_c : cover property (eff_code == `AIS_TEMP_FULL ##1
      pos_switch_en[13] && neg_switch_en[14]);
   seq_run_c : cover property (seq_mode && !shutdown ##1 seq_mode);
   shdn_burn_c : cover property (shutdown && burnout_source_en != 2'h0);
   err_resp_c : cover property (pready && pslverr);

endmodule : ais_top

`default_nettype wire

// ### test/adc_input_select_burnout_bench.sv
// Self-checking bench for the input selection and burnout control block.
// Assumes the common package, interface, header and core files are compiled first.
`default_nettype none
`include "ais_defines.svh"
`define CHK(got, exp, msg) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("BAD %0t %s", $time, msg); end end

module adc_input_select_burnout_bench;
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   typedef struct packed {
      logic [7:0] sel;
      logic [1:0] cs;
      logic [15:0] pos;
      logic [15:0] neg;
      logic [1:0] burn;
   } ais_row_type;
   // Wider address so that one offset above the map can be refused
   localparam logic [4:0] a_cfg = {1'b0, `AIS_OFS_CFG_FIRST};
   localparam logic [4:0] a_sel = {1'b0, `AIS_OFS_SELECT};
   localparam logic [4:0] a_ctl = {1'b0, `AIS_OFS_CONTROL};
   localparam logic [4:0] a_sts = {1'b0, `AIS_OFS_STATUS};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [4:0] paddr = 5'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] seq_code = 8'h00;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [15:0] pos_en;
   logic [15:0] neg_en;
   logic [1:0] src_en;
   logic [1:0] snk_en;
   logic [31:0] rd;
   logic err;
   logic tmp;
   int n_mismatch = 0;
   int checks = 0;
   // Eight-channel part: every channel code used here is bonded out
   ais_row_type rows [14] = '{
      '{8'h01, 2'h1, 16'h0001, 16'h0002, 2'h1}, '{8'h23, 2'h2, 16'h0004, 16'h0008, 2'h2},
      '{8'h45, 2'h3, 16'h0010, 16'h0020, 2'h3}, '{8'h67, 2'h1, 16'h0040, 16'h0080, 2'h1},
      '{8'h89, 2'h2, 16'h0100, 16'h0200, 2'h2}, '{8'hAB, 2'h3, 16'h0400, 16'h0800, 2'h3},
      '{8'hCF, 2'h3, 16'h1000, 16'h8000, 2'h3}, '{8'hDE, 2'h3, 16'h2000, 16'h4000, 2'h0},
      '{8'hED, 2'h2, 16'h4000, 16'h2000, 2'h0}, '{8'hFC, 2'h1, 16'h8000, 16'h1000, 2'h1},
      '{8'h3D, 2'h2, 16'h0008, 16'h2000, 2'h0}, '{8'h98, 2'h0, 16'h0200, 16'h0100, 2'h0},
      '{8'hE0, 2'h2, 16'h4000, 16'h0001, 2'h0},
      '{8'h77, 2'h1, 16'h0080, 16'h0080, 2'h1}};

   always #50 pclk = ~pclk;

   ais_top #(.ADDR_WIDTH(5)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .seq_code(seq_code), .pos_switch_en(pos_en), .neg_switch_en(neg_en),
      .burnout_source_en(src_en), .burnout_sink_en(snk_en));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic apb(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No fixed latency assumed; only the watchdog ends a dead wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic check_out(input logic [15:0] p, input logic [15:0] m, input logic [1:0] b);
      @(posedge pclk);
      @(negedge pclk);
      `CHK(pos_en, p, "positive switches")
      `CHK(neg_en, m, "negative switches")
      `CHK(src_en, b, "burnout source")
      `CHK(snk_en, b, "burnout sink")
   endtask : check_out

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : final_report

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      `CHK(pos_en, 16'h0000, "switches open in reset")
      @(posedge pclk);
      presetn <= 1'b1;
      check_out(16'h0001, 16'h0002, 2'h0);
      apb(1'b0, a_sel, 32'h0);
      `CHK(rd, 32'h0000_0001, "select reset value")
      apb(1'b0, a_cfg, 32'h0);
      `CHK(rd, 32'h0000_0000, "first config reset value")
      for (int i = 0; i < 14; i++) begin
         apb(1'b1, a_cfg, {30'h0, rows[i].cs});
         apb(1'b1, a_sel, {24'h0, rows[i].sel});
         check_out(rows[i].pos, rows[i].neg, rows[i].burn);
         tmp = rows[i].sel[7:4] inside {4'hD, 4'hE} || rows[i].sel[3:0] inside {4'hD, 4'hE};
         apb(1'b0, a_sts, 32'h0);
         `CHK(rd, {21'h0, tmp, rows[i].burn, rows[i].sel}, "status word")
      end
      // Sequencer overrides the field, then selects the diodes
      apb(1'b1, a_sel, 32'h12);
      seq_code <= 8'h34;
      apb(1'b1, a_ctl, 32'h1);
      check_out(16'h0008, 16'h0010, 2'h1);
      apb(1'b1, a_cfg, 32'h3);
      seq_code <= 8'hDE;
      check_out(16'h2000, 16'h4000, 2'h0);
      apb(1'b0, a_cfg, 32'h0);
      `CHK(rd, 32'h0000_0003, "select bits kept under diodes")
      // Shutdown opens switches; the burnout source stays on
      apb(1'b1, a_ctl, 32'h2);
      check_out(16'h0000, 16'h0000, 2'h3);
      apb(1'b1, a_cfg, 32'h2);
      check_out(16'h0000, 16'h0000, 2'h2);
      // Converter reset returns the selection and leaves the source alone
      apb(1'b1, a_ctl, 32'h4);
      check_out(16'h0001, 16'h0002, 2'h2);
      apb(1'b0, a_sel, 32'h0);
      `CHK(rd, 32'h0000_0001, "select after converter reset")
      // Refused accesses
      apb(1'b0, 5'h10, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0}, "unmapped read")
      apb(1'b1, 5'h05, 32'hFF);
      `CHK(err, 1'b1, "misaligned write")
      check_out(16'h0001, 16'h0002, 2'h2);
      // Mid-run reset clears the current select along with everything else
      @(posedge pclk);
      presetn <= 1'b0;
      @(negedge pclk);
      `CHK({pos_en, neg_en, src_en, snk_en}, 36'h0, "outputs in mid-run reset")
      `CHK({pready, pslverr}, 2'b00, "bus answer in mid-run reset")
      @(posedge pclk);
      presetn <= 1'b1;
      check_out(16'h0001, 16'h0002, 2'h0);
      apb(1'b0, a_cfg, 32'h0);
      `CHK(rd, 32'h0000_0000, "first config after mid-run reset")
      apb(1'b0, a_sel, 32'h0);
      `CHK(rd, 32'h0000_0001, "select after mid-run reset")
      final_report();
   end

   initial begin
      #200000;
      n_mismatch++;
      final_report();
   end
endmodule : adc_input_select_burnout_bench

`default_nettype wire
